// ==== src/vtx_pkg.sv ====
/*
 * constants for the vertex and label command decoder: opcodes, field
 * positions, reset values and the register map of its wishbone slave.
 * assumes nothing of its surroundings.
 */
package vtx_pkg;
    // ------------------------------------------------------------------
    // command opcodes, bits 31..24
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_TAG = 8'h03;
    localparam logic [7:0] OP_DEF_TAG = 8'h12;
    localparam logic [7:0] OP_TAG_GATE = 8'h14;
    localparam logic [7:0] OP_BEGIN = 8'h1F;
    localparam logic [7:0] OP_SAVE = 8'h22;
    localparam logic [7:0] OP_RESTORE = 8'h23;
    localparam logic [7:0] OP_CLEAR = 8'h26;
    localparam logic [7:0] OP_FRAC = 8'h27;
    localparam logic [7:0] OP_XSHIFT = 8'h2B;
    localparam logic [7:0] OP_YSHIFT = 8'h2C;
    // class in bits 31..30
    localparam logic [1:0] CLS_OPCODE = 2'h0;
    localparam logic [1:0] CLS_FINE = 2'h1;
    localparam logic [1:0] CLS_INT = 2'h2;
    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int CLS_HI = 31, CLS_LO = 30, OP_HI = 31, OP_LO = 24;
    localparam int FX_HI = 29, FX_LO = 15, FY_HI = 14, FY_LO = 0;
    localparam int IX_HI = 29, IX_LO = 21, IY_HI = 20, IY_LO = 12;
    localparam int IH_HI = 11, IH_LO = 7, IC_HI = 6, IC_LO = 0;
    localparam int LABEL_HI = 7, GATE_BIT = 0, FRAC_HI = 2, PRIM_HI = 3;
    localparam int SHIFT_HI = 16;
    localparam int FINE_W = 15, INT_W = 9, SUB_BITS = 4, COORD_W = 20;
    localparam int FRAC_W = 3, SHIFT_W = 17, LABEL_W = 8;
    localparam int HANDLE_W = 5, CELL_W = 7, PRIM_W = 4;
    localparam int CTX_W = 1 + FRAC_W + 2 * SHIFT_W;
    localparam int ATTR_W = LABEL_W + 1 + HANDLE_W + CELL_W;
    localparam int CTX_DEPTH = 4, CTX_PTR_W = 2;
    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [FRAC_W-1:0] FRAC_MAX = 3'h4;
    localparam logic [LABEL_W-1:0] LABEL_INIT = 8'hFF;
    localparam logic [LABEL_W-1:0] DEF_LABEL_INIT = 8'h00;
    localparam logic GATE_INIT = 1'b1;
    localparam logic [PRIM_W-1:0] PRIM_IMAGE = 4'h1;
    localparam logic [PRIM_W-1:0] PRIM_INIT = 4'h0;
    // ------------------------------------------------------------------
    // wishbone register map, byte addresses
    // ------------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] CMD_OFF = 8'h00;
    localparam logic [ADR_W-1:0] STATE_OFF = 8'h04;
    localparam logic [ADR_W-1:0] XPOS_OFF = 8'h08;
    localparam logic [ADR_W-1:0] YPOS_OFF = 8'h0C;
    localparam logic [ADR_W-1:0] VINFO_OFF = 8'h10;
    localparam logic [ADR_W-1:0] TOUCH_OFF = 8'h14;
    localparam logic [ADR_W-1:0] XSHIFT_OFF = 8'h18;
    localparam logic [ADR_W-1:0] YSHIFT_OFF = 8'h1C;
    localparam logic [3:0] SEL_ALL = 4'hF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
endpackage

// ==== src/ctx_stack.sv ====
/*
 * four deep stack of saved graphics state words.
 * assumes push and pop never arrive together; a push on a full stack
 * drops the oldest entry.
 */
`timescale 1ns/1ps
module ctx_stack import vtx_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requests
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [CTX_W-1:0] ctx_i,
    // top of stack
    output logic hit_o,
    output logic [CTX_W-1:0] ctx_o
);
    logic [CTX_W-1:0] mem_q [CTX_DEPTH];
    logic [CTX_PTR_W-1:0] ptr_q, ptr_d;
    logic [CTX_PTR_W:0] cnt_q, cnt_d;

    // pointer and fill level; a full push keeps the level and overwrites
    always_comb begin
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        if (push_i) begin
            ptr_d = ptr_q + 1'b1;
            if (cnt_q != (CTX_PTR_W+1)'(CTX_DEPTH))
                cnt_d = cnt_q + 1'b1;
        end else if (pop_i && cnt_q != '0) begin
            ptr_d = ptr_q - 1'b1;
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // storage written at the pointer
    always_ff @(posedge clk_i) begin
        if (push_i)
            mem_q[ptr_q] <= ctx_i;
    end

    assign hit_o = (cnt_q != '0);
    assign ctx_o = mem_q[ptr_q - 1'b1];
endmodule // ctx_stack

// ==== src/vertex_calc.sv ====
/*
 * turns a point command into screen coordinates in 1/16 pixel,
 * registered, one cycle after the strobe.
 * assumes fine_i and int_i are never high together.
 */
`timescale 1ns/1ps
module vertex_calc import vtx_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command
    input wire logic fine_i,
    input wire logic int_i,
    input wire logic [31:0] word_i,
    input wire logic [FRAC_W-1:0] frac_i,
    input wire logic [SHIFT_W-1:0] xshift_i,
    input wire logic [SHIFT_W-1:0] yshift_i,
    input wire logic [ATTR_W-1:0] attr_i,
    // result
    output logic valid_o,
    output logic [COORD_W-1:0] x_o,
    output logic [COORD_W-1:0] y_o,
    output logic [ATTR_W-1:0] attr_o
);
    logic valid_d;
    logic [COORD_W-1:0] x_d, y_d;
    logic [ATTR_W-1:0] attr_d;

    // signed fixed point, rescaled to sixteenths
    function automatic logic [COORD_W-1:0] fine_scale(
            input logic [FINE_W-1:0] v, input logic [FRAC_W-1:0] f);
        logic [COORD_W-1:0] s;
        s = {{(COORD_W-FINE_W){v[FINE_W-1]}}, v};
        return s << (FRAC_MAX - f);
    endfunction

    function automatic logic [COORD_W-1:0] int_scale(
            input logic [INT_W-1:0] v);
        return {{(COORD_W-INT_W-SUB_BITS){1'b0}}, v, {SUB_BITS{1'b0}}};
    endfunction

    function automatic logic [COORD_W-1:0] shift_ext(
            input logic [SHIFT_W-1:0] v);
        return {{(COORD_W-SHIFT_W){v[SHIFT_W-1]}}, v};
    endfunction

    // next coordinate; translation applies to both kinds
    always_comb begin
        valid_d = fine_i | int_i;
        x_d = x_o;
        y_d = y_o;
        attr_d = attr_o;
        if (fine_i) begin
            x_d = fine_scale(word_i[FX_HI:FX_LO], frac_i) + shift_ext(xshift_i);
            y_d = fine_scale(word_i[FY_HI:FY_LO], frac_i) + shift_ext(yshift_i);
            attr_d = attr_i;
        end else if (int_i) begin
            x_d = int_scale(word_i[IX_HI:IX_LO]) + shift_ext(xshift_i);
            y_d = int_scale(word_i[IY_HI:IY_LO]) + shift_ext(yshift_i);
            attr_d = attr_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            x_o <= '0;
            y_o <= '0;
            attr_o <= '0;
        end else begin
            valid_o <= valid_d;
            x_o <= x_d;
            y_o <= y_d;
            attr_o <= attr_d;
        end
    end
endmodule // vertex_calc

// ==== src/vertex_tag_cmd_decoder.sv ====
/*
 * display list word decoder for vertex, precision, translation and
 * label commands, reached as a classic wishbone slave.
 * assumes one clock, synchronous reset, and a touch engine on the
 * same clock presenting touch_hit_i with the label of the hit object.
 */
// The register offsets and the Wishbone register port are this design's own decisions.
// Notes on behaviour
// - opcode 0x14 sets the label gate from bit 0
// - gate at one: label command loads the label buffer
// - gate at zero: buffer takes default, label commands ignored
// - default label set by its command, applied by clear; resets zero
// - every point carries the current label buffer value
// - fine point: signed x bits 29..15, y bits 14..0
// - fine point unit follows precision, 1/16 pixel until changed
// - integer point: class 2, x, y, handle, cell fields
// - handle and cell ignored unless image primitive selected
// - opcode 0x27 sets fraction bits, valid 0..4, reset 4
// - fine coordinates are 15-bit fixed point with that fraction
// - opcode 0x2B sets x offset in sixteenths, added to points
// - opcode 0x2C sets y offset in sixteenths, added to points
// - gate, fraction and offsets are saved and restored state
// - touched object updates the touched-label register
`timescale 1ns/1ps
module vertex_tag_cmd_decoder import vtx_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // touch engine
    input wire logic touch_hit_i,
    input wire logic [LABEL_W-1:0] touch_tag_i,
    // vertex stream
    output logic vtx_valid_o,
    output logic [COORD_W-1:0] vtx_x_o,
    output logic [COORD_W-1:0] vtx_y_o,
    output logic [LABEL_W-1:0] vtx_tag_o,
    output logic vtx_bitmap_o,
    output logic [HANDLE_W-1:0] vtx_handle_o,
    output logic [CELL_W-1:0] vtx_cell_o
);
    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    bus_state_t state_q, state_d;
    logic [31:0] rdata_q, rdata_d;
    logic cmd_fire;

    // opcode match, only for words outside the two point classes
    function automatic logic is_op(input logic [31:0] w,
                                   input logic [7:0] op);
        return w[CLS_HI:CLS_LO] == CLS_OPCODE && w[OP_HI:OP_LO] == op;
    endfunction

    // ------------------------------------------------------------------
    // graphics state
    // ------------------------------------------------------------------
    logic gate_q, gate_d;
    logic [FRAC_W-1:0] frac_q, frac_d;
    logic [SHIFT_W-1:0] xsh_q, xsh_d, ysh_q, ysh_d;
    logic [LABEL_W-1:0] label_q, label_d, def_q, def_d;
    logic [PRIM_W-1:0] prim_q, prim_d;
    logic [LABEL_W-1:0] touch_q, touch_d;
    logic [15:0] vcnt_q, vcnt_d;
    logic fine_hit, int_hit, save_hit, restore_hit, image_sel, cell_sel;
    logic ctx_hit;
    logic [CTX_W-1:0] ctx_top, ctx_now;
    logic [ATTR_W-1:0] attr_now, attr_out;

    // word handed to the decoder at the edge that carries ack
    assign cmd_fire = (state_q == BUS_ACK) && we_i && adr_i == CMD_OFF
                      && sel_i == SEL_ALL;

    // point class decided from the top two bits first
    assign fine_hit = cmd_fire && dat_i[CLS_HI:CLS_LO] == CLS_FINE;
    assign int_hit = cmd_fire && dat_i[CLS_HI:CLS_LO] == CLS_INT;
    assign save_hit = cmd_fire && is_op(dat_i, OP_SAVE);
    assign restore_hit = cmd_fire && is_op(dat_i, OP_RESTORE);
    assign image_sel = (prim_q == PRIM_IMAGE);
    assign cell_sel = image_sel && int_hit;
    assign ctx_now = {gate_q, frac_q, xsh_q, ysh_q};

    // label, handle and cell travel with the point; handle and cell
    // read as zero unless the image primitive is current and the word
    // is an integer point: a fine point holds y in those bits
    assign attr_now = {label_q, image_sel,
        cell_sel ? dat_i[IH_HI:IH_LO] : {HANDLE_W{1'b0}},
        cell_sel ? dat_i[IC_HI:IC_LO] : {CELL_W{1'b0}}};

    // bus handshake: ack one cycle after the request, for one cycle
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        case (state_q)
            BUS_IDLE: begin
                if (cyc_i && stb_i) begin
                    state_d = BUS_ACK;
                    case (adr_i)
                        STATE_OFF: rdata_d = {11'h000, image_sel, frac_q,
                            gate_q, def_q, label_q};
                        XPOS_OFF: rdata_d = {{(32-COORD_W){vtx_x_o[COORD_W-1]}},
                            vtx_x_o};
                        YPOS_OFF: rdata_d = {{(32-COORD_W){vtx_y_o[COORD_W-1]}},
                            vtx_y_o};
                        VINFO_OFF: rdata_d = {vcnt_q, 3'h0, vtx_handle_o,
                            vtx_bitmap_o, vtx_cell_o};
                        TOUCH_OFF: rdata_d = {24'h00_0000, touch_q};
                        XSHIFT_OFF: rdata_d = {{(32-SHIFT_W){xsh_q[SHIFT_W-1]}},
                            xsh_q};
                        YSHIFT_OFF: rdata_d = {{(32-SHIFT_W){ysh_q[SHIFT_W-1]}},
                            ysh_q};
                        default: rdata_d = ZERO_WORD;
                    endcase
                end
            end
            BUS_ACK: state_d = BUS_IDLE;
            default: state_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= BUS_IDLE;
            rdata_q <= ZERO_WORD;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
        end
    end

    assign ack_o = (state_q == BUS_ACK);
    assign dat_o = rdata_q;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    // next graphics state from the fired word
    always_comb begin
        gate_d = gate_q;
        frac_d = frac_q;
        xsh_d = xsh_q;
        ysh_d = ysh_q;
        label_d = label_q;
        def_d = def_q;
        prim_d = prim_q;
        vcnt_d = vcnt_q;
        if (fine_hit || int_hit)
            vcnt_d = vcnt_q + 1'b1;
        if (cmd_fire) begin
            if (is_op(dat_i, OP_TAG_GATE)) begin
                gate_d = dat_i[GATE_BIT];
                if (!dat_i[GATE_BIT])
                    label_d = def_q;
            end
            if (is_op(dat_i, OP_TAG) && gate_q)
                label_d = dat_i[LABEL_HI:0];
            if (is_op(dat_i, OP_DEF_TAG))
                def_d = dat_i[LABEL_HI:0];
            if (is_op(dat_i, OP_CLEAR))
                label_d = def_q;
            if (is_op(dat_i, OP_BEGIN))
                prim_d = dat_i[PRIM_HI:0];
            if (is_op(dat_i, OP_FRAC) && dat_i[FRAC_HI:0] <= FRAC_MAX)
                frac_d = dat_i[FRAC_HI:0];
            if (is_op(dat_i, OP_XSHIFT))
                xsh_d = dat_i[SHIFT_HI:0];
            if (is_op(dat_i, OP_YSHIFT))
                ysh_d = dat_i[SHIFT_HI:0];
            if (restore_hit && ctx_hit) begin
                {gate_d, frac_d, xsh_d, ysh_d} = ctx_top;
                if (!ctx_top[CTX_W-1])
                    label_d = def_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_q <= GATE_INIT;
            frac_q <= FRAC_MAX;
            xsh_q <= '0;
            ysh_q <= '0;
            label_q <= LABEL_INIT;
            def_q <= DEF_LABEL_INIT;
            prim_q <= PRIM_INIT;
            vcnt_q <= '0;
        end else begin
            gate_q <= gate_d;
            frac_q <= frac_d;
            xsh_q <= xsh_d;
            ysh_q <= ysh_d;
            label_q <= label_d;
            def_q <= def_d;
            prim_q <= prim_d;
            vcnt_q <= vcnt_d;
        end
    end

    // touched label follows each hit reported by the touch engine
    always_comb begin
        touch_d = touch_hit_i ? touch_tag_i : touch_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            touch_q <= '0;
        else
            touch_q <= touch_d;
    end

    // ------------------------------------------------------------------
    // saved state and vertex arithmetic
    // ------------------------------------------------------------------
    ctx_stack u_ctx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(save_hit),
        .pop_i(restore_hit),
        .ctx_i(ctx_now),
        .hit_o(ctx_hit),
        .ctx_o(ctx_top)
    );

    // fine points scaled by the fraction, offsets added to both kinds
    vertex_calc u_calc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fine_i(fine_hit),
        .int_i(int_hit),
        .word_i(dat_i),
        .frac_i(frac_q),
        .xshift_i(xsh_q),
        .yshift_i(ysh_q),
        .attr_i(attr_now),
        .valid_o(vtx_valid_o),
        .x_o(vtx_x_o),
        .y_o(vtx_y_o),
        .attr_o(attr_out)
    );

    assign {vtx_tag_o, vtx_bitmap_o, vtx_handle_o, vtx_cell_o} = attr_out;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [COORD_W-1:0] exp_fine_x, exp_int_x, exp_shift_x;
    assign exp_shift_x = {{(COORD_W-SHIFT_W){xsh_q[SHIFT_W-1]}}, xsh_q};
    assign exp_fine_x = {{(COORD_W-FINE_W){dat_i[FX_HI]}},
        dat_i[FX_HI:FX_LO]} + exp_shift_x;
    assign exp_int_x = {{(COORD_W-INT_W-SUB_BITS){1'b0}},
        dat_i[IX_HI:IX_LO], {SUB_BITS{1'b0}}} + exp_shift_x;

    sequence point_issue;
        fine_hit || int_hit;
    endsequence

    sequence point_out(logic [LABEL_W-1:0] lbl);
        vtx_valid_o && vtx_tag_o == lbl;
    endsequence

    bus_ack_a: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o
        ##1 !ack_o) else $error("ack not a single cycle after request");

    gate_cmd_a: assert property (
        (cmd_fire && is_op(dat_i, OP_TAG_GATE))
        |=> gate_q == $past(dat_i[GATE_BIT]))
        else $error("gate flag not taken from bit 0");

    tag_load_a: assert property (
        (cmd_fire && is_op(dat_i, OP_TAG) && gate_q && !restore_hit)
        |=> label_q == $past(dat_i[LABEL_HI:0]))
        else $error("label not loaded with gate open");

    tag_ignore_a: assert property (
        (cmd_fire && is_op(dat_i, OP_TAG) && !gate_q)
        |=> $stable(label_q))
        else $error("label changed with gate closed");

    clear_default_a: assert property (
        (cmd_fire && is_op(dat_i, OP_CLEAR))
        |=> label_q == $past(def_q))
        else $error("clear did not apply default label");

    def_tag_a: assert property (
        (cmd_fire && is_op(dat_i, OP_DEF_TAG))
        |=> def_q == $past(dat_i[LABEL_HI:0]))
        else $error("default label not stored");

    vertex_tag_a: assert property (
        point_issue |=> point_out($past(label_q)))
        else $error("point lacks current label");

    fine_point_a: assert property (
        (fine_hit && frac_q == FRAC_MAX)
        |=> vtx_x_o == $past(exp_fine_x))
        else $error("fine point x wrong at sixteenths");

    frac_range_a: assert property (
        frac_q <= FRAC_MAX)
        else $error("fraction bits above four");

    frac_bad_a: assert property (
        (cmd_fire && is_op(dat_i, OP_FRAC) && dat_i[FRAC_HI:0] > FRAC_MAX)
        |=> $stable(frac_q))
        else $error("illegal fraction accepted");

    int_point_a: assert property (
        int_hit |=> vtx_x_o == $past(exp_int_x))
        else $error("integer point x wrong");

    image_gate_a: assert property (
        (int_hit && !image_sel) |=> !vtx_bitmap_o
        && vtx_handle_o == '0 && vtx_cell_o == '0)
        else $error("handle passed outside image primitive");

    xshift_set_a: assert property (
        (cmd_fire && is_op(dat_i, OP_XSHIFT) && !restore_hit)
        |=> xsh_q == $past(dat_i[SHIFT_HI:0]))
        else $error("x offset not stored");

    yshift_set_a: assert property (
        (cmd_fire && is_op(dat_i, OP_YSHIFT) && !restore_hit)
        |=> ysh_q == $past(dat_i[SHIFT_HI:0]))
        else $error("y offset not stored");

    restore_ctx_a: assert property (
        (restore_hit && ctx_hit)
        |=> {gate_q, frac_q, xsh_q, ysh_q} == $past(ctx_top))
        else $error("state not restored");

    touch_label_a: assert property (
        touch_hit_i |=> touch_q == $past(touch_tag_i))
        else $error("touched label not updated");

    class_first_a: assert property (
        (cmd_fire && dat_i[CLS_HI] ^ dat_i[CLS_LO])
        |=> $stable(label_q) && $stable(gate_q))
        else $error("point word decoded as opcode");
endmodule // vertex_tag_cmd_decoder

// ==== verif/list_writer.sv ====
/*
 * display list writer model: classic wishbone master, one word per go.
 * assumes a slave that acks while cyc and stb are high.
 */
`timescale 1ns/1ps
module list_writer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request from the bench
    input wire logic go_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic done_o,
    output logic [31:0] rd_o,
    // wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic ack_i,
    input wire logic [31:0] rdat_i
);
    // one transfer at a time; lines change when released
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cyc_o <= 1'b0;
            stb_o <= 1'b0;
            we_o <= 1'b0;
            adr_o <= 8'h00;
            dat_o <= 32'h0000_0000;
        end else if (cyc_o && ack_i) begin
            cyc_o <= 1'b0;
            stb_o <= 1'b0;
            done_o <= 1'b1;
            rd_o <= rdat_i;
            dat_o <= ~dat_o;
            adr_o <= ~adr_o;
        end else if (go_i && !cyc_o && !done_o) begin
            cyc_o <= 1'b1;
            stb_o <= 1'b1;
            we_o <= we_i;
            adr_o <= adr_i;
            sel_o <= sel_i;
            dat_o <= dat_i;
        end
    end
endmodule // list_writer

// ==== verif/vertex_tag_cmd_decoder_test.sv ====
/*
 * self-checking bench for the vertex and label decoder.
 * assumes list_writer as bus master and a same-clock touch pulse.
 */
`timescale 1ns/1ps
module vertex_tag_cmd_decoder_test import vtx_pkg::*;;
    logic clk_i = 0, rst_i = 1, go = 0, we = 0, hit = 0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00, htag = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    wire cyc, stb, wwe, ack, done, vv, vb;
    wire [3:0] wsel;
    wire [7:0] wadr, vt;
    wire [31:0] wdat, rdat, rd;
    wire [19:0] vx, vy;
    wire [4:0] vh;
    wire [6:0] vc;
    int num_errors = 0, samples_checked = 0, seed = 49, i;
    logic g;
    logic [2:0] fr;
    logic [16:0] xs, ys;
    logic [7:0] lb, dl;
    logic [3:0] pr;
    logic [37:0] stk[$];
    logic [60:0] exp_q[$];
    logic [7:0] ops[10] = '{OP_TAG, OP_DEF_TAG, OP_TAG_GATE, OP_BEGIN,
        OP_SAVE, OP_RESTORE, OP_CLEAR, OP_FRAC, OP_XSHIFT, OP_YSHIFT};
    // clock and instances
    initial forever #20 clk_i = ~clk_i;
    vertex_tag_cmd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(wwe), .adr_i(wadr), .sel_i(wsel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .touch_hit_i(hit), .touch_tag_i(htag),
        .vtx_valid_o(vv), .vtx_x_o(vx), .vtx_y_o(vy), .vtx_tag_o(vt),
        .vtx_bitmap_o(vb), .vtx_handle_o(vh), .vtx_cell_o(vc));
    list_writer wr (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .done_o(done), .rd_o(rd),
        .cyc_o(cyc), .stb_o(stb), .we_o(wwe), .adr_o(wadr), .sel_o(wsel),
        .dat_o(wdat), .ack_i(ack), .rdat_i(rdat));
    // -----------------------------------------------------------------
    // reporting
    // -----------------------------------------------------------------
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected register exp %h got %h", e, s);
        end
    endtask
    task automatic check_vtx(input logic [60:0] e, input logic [60:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected vertex exp %h got %h", e, s);
        end
    endtask
    // -----------------------------------------------------------------
    // bus access and command model
    // -----------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        go <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk_i);
        go <= 1'b0;
        if (done !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask
    function automatic logic [31:0] st();
        return {11'h000, pr == PRIM_IMAGE, fr, g, dl, lb};
    endfunction
    task automatic cmd(input logic [31:0] w);
        logic bm, hc;
        logic [19:0] x, y;
        bm = (pr == PRIM_IMAGE);
        hc = bm && w[31:30] == CLS_INT;
        if (w[31:30] == CLS_FINE) begin
            x = {{5{w[29]}}, w[29:15]} << (SUB_BITS - fr);
            y = {{5{w[14]}}, w[14:0]} << (SUB_BITS - fr);
        end else begin
            x = {7'h00, w[29:21], 4'h0};
            y = {7'h00, w[20:12], 4'h0};
        end
        if (w[31:30] != CLS_OPCODE) exp_q.push_back({x + {{3{xs[16]}}, xs},
            y + {{3{ys[16]}}, ys}, lb, bm, hc ? w[11:7] : 5'h00,
            hc ? w[6:0] : 7'h00});
        else case (w[31:24])
            OP_TAG: if (g) lb = w[7:0];
            OP_DEF_TAG: dl = w[7:0];
            OP_TAG_GATE: begin
                g = w[0];
                if (!g) lb = dl;
            end
            OP_BEGIN: pr = w[3:0];
            OP_SAVE: begin
                stk.push_back({g, fr, xs, ys});
                if (stk.size() > CTX_DEPTH) void'(stk.pop_front());
            end
            OP_RESTORE: if (stk.size() > 0) begin
                {g, fr, xs, ys} = stk.pop_back();
                if (!g) lb = dl;
            end
            OP_CLEAR: lb = dl;
            OP_FRAC: if (w[2:0] <= FRAC_MAX) fr = w[2:0];
            OP_XSHIFT: xs = w[16:0];
            OP_YSHIFT: ys = w[16:0];
            default: ;
        endcase
        bus(1'b1, CMD_OFF, w, SEL_ALL);
    endtask
    // each issued point is compared against the oldest note
    always @(posedge clk_i) begin
        if (vv === 1'b1) begin
            if (exp_q.size() == 0) check_vtx(61'h0, ~{vx, vy, vt, vb, vh, vc});
            else check_vtx(exp_q.pop_front(), {vx, vy, vt, vb, vh, vc});
        end
    end
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        logic [31:0] w;
        int k;
        g = GATE_INIT;
        fr = FRAC_MAX;
        xs = 17'h0_0000;
        ys = 17'h0_0000;
        lb = LABEL_INIT;
        dl = DEF_LABEL_INIT;
        pr = PRIM_INIT;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, STATE_OFF, ZERO_WORD, SEL_ALL);
        check_reg(st(), rd);
        $display("test reset done");
        for (i = 0; i < 400; i++) begin
            k = {$random(seed)} % 12;
            w = $random(seed);
            if (k < 10) w[31:24] = ops[k];
            if (k == 10) w[31:30] = CLS_FINE;
            if (k == 11) w[31:30] = CLS_INT;
            if (k == 0 && w[7:0] == 8'h00) w[0] = 1'b1;
            if (k == 3) w[3:1] = 3'h0;
            cmd(w);
        end
        $display("test random list done");
        bus(1'b1, CMD_OFF, {OP_TAG, 24'h00_005A}, 4'h7);
        bus(1'b1, STATE_OFF, 32'hFFFF_FFFF, SEL_ALL);
        bus(1'b0, STATE_OFF, ZERO_WORD, SEL_ALL);
        check_reg(st(), rd);
        bus(1'b0, XSHIFT_OFF, ZERO_WORD, SEL_ALL);
        check_reg({{15{xs[16]}}, xs}, rd);
        bus(1'b0, 8'h20, ZERO_WORD, SEL_ALL);
        check_reg(ZERO_WORD, rd);
        $display("test refused accesses done");
        @(posedge clk_i);
        hit <= 1'b1;
        htag <= 8'h3C;
        @(posedge clk_i);
        hit <= 1'b0;
        bus(1'b0, TOUCH_OFF, ZERO_WORD, SEL_ALL);
        check_reg(32'h0000_003C, rd);
        check_reg(ZERO_WORD, 32'(exp_q.size()));
        $display("test touch done");
        close_out();
    end
endmodule // vertex_tag_cmd_decoder_test
